// file: core/cmpsel_defs.svh
// Overview of operation
// - Bits 1 to 0 of each control B register pick which of four shared minus pins feeds that comparator's minus input.
// - Minus select code 00 picks shared pin 0, 01 pin 1, 10 pin 2 and 11 pin 3.
// - The output mirror register shows comparator 2's live result at bit 1 and comparator 1's at bit 0.
// - Mirror bits 7 to 2 and control B bits 3 to 2 read as zero and ignore writes.
// - All control B fields and both mirror bits are zero after any reset.
`ifndef CMPSEL_DEFS_SVH
`define CMPSEL_DEFS_SVH

// =====================================================================
// Register offsets
`define CMPSEL_OFF_CTRLB1 4'h0
`define CMPSEL_OFF_CTRLB2 4'h1
`define CMPSEL_OFF_MIRROR 4'h2
`define CMPSEL_OFF_FLAGS 4'h3

// =====================================================================
// Field positions of control B
`define CMPSEL_BIT_RISE 7
`define CMPSEL_BIT_FALL 6
`define CMPSEL_PSEL_HI 5
`define CMPSEL_PSEL_LO 4
`define CMPSEL_NSEL_HI 1
`define CMPSEL_NSEL_LO 0
`define CMPSEL_CTRLB_MASK 8'hF3

// =====================================================================
// Reset values
`define CMPSEL_CTRLB_RST 8'h00
`define CMPSEL_MIRROR_RST 2'h0

`endif

// file: core/cmpsel_pkg.sv
package cmpsel_pkg;
	// Plus input source choices
	typedef enum logic [1:0] {
		CMPSEL_PLUS_PIN = 2'b00,
		CMPSEL_PLUS_DAC = 2'b01,
		CMPSEL_PLUS_FIXED = 2'b10,
		CMPSEL_PLUS_GND = 2'b11
	} cmpsel_plus_e;
	typedef logic [7:0] cmpsel_byte_t;
endpackage : cmpsel_pkg

// file: core/cmpsel_edge.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmpsel_defs.svh"
// One comparator: synchroniser, edge detector and sticky flag
module cmpsel_edge (
	input wire logic clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic result_async, // Raw comparator result
	input wire logic rise_en, // Rising edge enable
	input wire logic fall_en, // Falling edge enable
	input wire logic flag_clr, // One-cycle clear from software
	output logic result_sync, // Synchronised result
	output logic flag // Sticky edge flag
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;
	logic flag_reg;
	wire logic rise_hit;
	wire logic fall_hit;
	wire logic flag_next;

	// =================================================================
	// Edge decode; set beats a clear in the same cycle
	assign rise_hit = rise_en & sync_reg & ~prev_reg;
	assign fall_hit = fall_en & ~sync_reg & prev_reg;
	assign flag_next = (rise_hit | fall_hit) | (flag_reg & ~flag_clr);

	// Analog result is asynchronous, so two stages before any logic
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
			flag_reg <= 1'b0;
		end else begin
			meta_reg <= result_async;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
			flag_reg <= flag_next;
		end
	end

	assign result_sync = sync_reg;
	assign flag = flag_reg;
endmodule : cmpsel_edge
`default_nettype wire

// file: core/cmpsel_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmpsel_defs.svh"
// Comparator input select, output mirror and edge flag logic
module cmpsel_top (
	input wire logic clk, // System clock, 25 MHz
	input wire logic rst, // Async reset, high
	input wire logic [3:0] addr, // Register address
	input wire logic [7:0] wdata, // Write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [7:0] rdata, // Read data, cycle after rd
	input wire logic comparator_result_1, // Raw result, comparator 1
	input wire logic comparator_result_2, // Raw result, comparator 2
	output logic [1:0] plus_input_select_1, // Plus source, comparator 1
	output logic [1:0] plus_input_select_2, // Plus source, comparator 2
	output logic [1:0] minus_input_select_1, // Minus pin, comparator 1
	output logic [1:0] minus_input_select_2, // Minus pin, comparator 2
	output logic [3:0] minus_pin_onehot_1, // Shared pin switches, cmp 1
	output logic [3:0] minus_pin_onehot_2, // Shared pin switches, cmp 2
	output logic cmp1_irq_flag, // Sticky edge flag, comparator 1
	output logic cmp2_irq_flag // Sticky edge flag, comparator 2
);
	cmpsel_pkg::cmpsel_byte_t ctrlb1_reg;
	cmpsel_pkg::cmpsel_byte_t ctrlb2_reg;
	cmpsel_pkg::cmpsel_byte_t rdata_reg;
	cmpsel_pkg::cmpsel_byte_t rdata_next;
	wire logic sel_b1;
	wire logic sel_b2;
	wire logic sel_mir;
	wire logic sel_flg;
	wire logic [1:0] mirror;
	wire logic [1:0] flags;
	wire logic [1:0] flag_clr;

	// Minus select code maps straight to a shared pin index
	function automatic logic [3:0] pin_decode(input logic [1:0] code);
		pin_decode = 4'h1 << code;
	endfunction : pin_decode

	// =================================================================
	// Address decode
	assign sel_b1 = (addr == `CMPSEL_OFF_CTRLB1);
	assign sel_b2 = (addr == `CMPSEL_OFF_CTRLB2);
	assign sel_mir = (addr == `CMPSEL_OFF_MIRROR);
	assign sel_flg = (addr == `CMPSEL_OFF_FLAGS);
	// Write one to clear a flag bit
	assign flag_clr = (wr & sel_flg) ? wdata[1:0] : 2'h0;

	// =================================================================
	// Control B registers; reserved bits are masked off on write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlb1_reg <= `CMPSEL_CTRLB_RST;
			ctrlb2_reg <= `CMPSEL_CTRLB_RST;
		end else begin
			if (wr & sel_b1)
				ctrlb1_reg <= wdata & `CMPSEL_CTRLB_MASK;
			if (wr & sel_b2)
				ctrlb2_reg <= wdata & `CMPSEL_CTRLB_MASK;
		end
	end

	// =================================================================
	// Per-comparator edge logic
	cmpsel_edge u_edge1 (
		.clk(clk),
		.rst(rst),
		.result_async(comparator_result_1),
		.rise_en(ctrlb1_reg[`CMPSEL_BIT_RISE]),
		.fall_en(ctrlb1_reg[`CMPSEL_BIT_FALL]),
		.flag_clr(flag_clr[0]),
		.result_sync(mirror[0]),
		.flag(flags[0])
	);
	cmpsel_edge u_edge2 (
		.clk(clk),
		.rst(rst),
		.result_async(comparator_result_2),
		.rise_en(ctrlb2_reg[`CMPSEL_BIT_RISE]),
		.fall_en(ctrlb2_reg[`CMPSEL_BIT_FALL]),
		.flag_clr(flag_clr[1]),
		.result_sync(mirror[1]),
		.flag(flags[1])
	);

	// =================================================================
	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_next = 8'h00;
		if (sel_b1)
			rdata_next = ctrlb1_reg;
		else if (sel_b2)
			rdata_next = ctrlb2_reg;
		else if (sel_mir)
			rdata_next = {6'h00, mirror};
		else if (sel_flg)
			rdata_next = {6'h00, flags};
	end

	// Read data held only in the cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rd ? rdata_next : 8'h00;
	end

	// =================================================================
	// Analog routing controls
	assign plus_input_select_1 =
		ctrlb1_reg[`CMPSEL_PSEL_HI:`CMPSEL_PSEL_LO];
	assign plus_input_select_2 =
		ctrlb2_reg[`CMPSEL_PSEL_HI:`CMPSEL_PSEL_LO];
	assign minus_input_select_1 =
		ctrlb1_reg[`CMPSEL_NSEL_HI:`CMPSEL_NSEL_LO];
	assign minus_input_select_2 =
		ctrlb2_reg[`CMPSEL_NSEL_HI:`CMPSEL_NSEL_LO];
	assign minus_pin_onehot_1 = pin_decode(minus_input_select_1);
	assign minus_pin_onehot_2 = pin_decode(minus_input_select_2);
	assign rdata = rdata_reg;
	assign cmp1_irq_flag = flags[0];
	assign cmp2_irq_flag = flags[1];
endmodule : cmpsel_top
`default_nettype wire

// file: test/cmpsel_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module cmpsel_top_chk (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic [3:0] addr, // Address
	input wire logic [7:0] wdata, // Data in
	input wire logic wr, // Write
	input wire logic rd, // Read
	input wire logic [7:0] rdata, // Data out
	input wire logic [1:0] minus_input_select_1, // Minus 1
	input wire logic [1:0] minus_input_select_2, // Minus 2
	input wire logic [3:0] minus_pin_onehot_1, // Pins 1
	input wire logic [3:0] minus_pin_onehot_2, // Pins 2
	input wire logic cmp1_irq_flag, // Flag 1
	input wire logic cmp2_irq_flag // Flag 2
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Pin switches follow the code, never two closed at once
	AST_PIN1: assert property (minus_pin_onehot_1 ==
		4'h1 << minus_input_select_1) else $error("pins 1");
	AST_PIN2: assert property (minus_pin_onehot_2 ==
		4'h1 << minus_input_select_2) else $error("pins 2");
	// Written codes land one cycle on
	AST_WR1: assert property (wr && addr == 4'h0 |=>
		minus_input_select_1 == $past(wdata[1:0])) else $error("sel 1");
	AST_WR2: assert property (wr && addr == 4'h1 |=>
		minus_input_select_2 == $past(wdata[1:0])) else $error("sel 2");
	// Empty positions read as zero
	AST_RDC: assert property (rd && addr == 4'h1 |=>
		rdata[3:2] == 2'h0) else $error("ctrl gap");
	AST_RDM: assert property (rd && addr == 4'h2 |=>
		rdata[7:2] == 6'h00) else $error("mirror gap");
	// Read data stand only in the cycle after a read strobe
	AST_RDZ: assert property (!rd |=> rdata == 8'h00)
		else $error("rdata not idle");
	// Flags are sticky until a clear is written
	AST_FLG1: assert property (cmp1_irq_flag &&
		!(wr && addr == 4'h3 && wdata[0]) |=> cmp1_irq_flag)
		else $error("flag 1 lost");
	AST_FLG2: assert property (cmp2_irq_flag &&
		!(wr && addr == 4'h3 && wdata[1]) |=> cmp2_irq_flag)
		else $error("flag 2 lost");
endmodule : cmpsel_top_chk
bind cmpsel_top cmpsel_top_chk cmpsel_top_chk_i (.clk(clk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.minus_input_select_1(minus_input_select_1),
	.minus_input_select_2(minus_input_select_2),
	.minus_pin_onehot_1(minus_pin_onehot_1),
	.minus_pin_onehot_2(minus_pin_onehot_2),
	.cmp1_irq_flag(cmp1_irq_flag), .cmp2_irq_flag(cmp2_irq_flag));
`default_nettype wire

// file: test/test_cmpsel_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Self-checking bench
module test_cmpsel_top;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, r1 = 1'b0, r2 = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, d, rdata;
	logic [1:0] p1, p2, m1, m2;
	logic [3:0] o1, o2;
	logic f1, f2;
	int err_total = 0, check_count = 0;
	cmpsel_top cmpsel_top_i (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.comparator_result_1(r1), .comparator_result_2(r2),
		.plus_input_select_1(p1), .plus_input_select_2(p2),
		.minus_input_select_1(m1), .minus_input_select_2(m2),
		.minus_pin_onehot_1(o1), .minus_pin_onehot_2(o2),
		.cmp1_irq_flag(f1), .cmp2_irq_flag(f2));
	initial forever #20 clk = ~clk;
	// Expected values: gap bits masked, pins one-hot
	function automatic logic [7:0] cexp(input logic [7:0] v);
		return v & 8'hF3;
	endfunction : cexp
	function automatic logic [3:0] hot(input logic [1:0] c);
		return 4'h1 << c;
	endfunction : hot
	task chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Bus cycles; strobe dropped on the next edge so calls never overlap
	task wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		{addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task rreg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask : rreg
	task conclude;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	// Run takes about 234 cycles; 3000, over twelve times that, means a hang
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		conclude();
	end
	initial begin
		void'($urandom(97));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		#1 chk({p1, p2, m1, m2}, 8'h00);
		chk({o1, o2}, 8'h11);
		for (int a = 0; a < 4; a++) rreg(4'(a), 8'h00);
		// Every plus and minus code on both, random enable bits
		for (int i = 0; i < 16; i++) begin
			d = 8'($urandom);
			d[5:4] = 2'(i);
			d[1:0] = 2'(i >> 2);
			wreg(4'h0, d);
			wreg(4'h1, ~d);
			rreg(4'h0, cexp(d));
			rreg(4'h1, cexp(~d));
			chk({p1, m1, p2, m2}, {d[5:4], d[1:0], ~d[5:4], ~d[1:0]});
			chk({o1, o2}, {hot(d[1:0]), hot(~d[1:0])});
		end
		// Mirror follows results, ignores writes
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) {r2, r1} <= 2'($urandom);
			wreg(4'h2, 8'hFF);
			rreg(4'h2, {6'h00, r2, r1});
		end
		rreg(4'h9, 8'h00);
		// Rise enabled on 1, fall enabled on 2
		wreg(4'h0, 8'h80);
		wreg(4'h1, 8'h40);
		@(posedge clk) {r2, r1} <= 2'b10;
		repeat (4) @(posedge clk);
		wreg(4'h3, 8'h03);
		rreg(4'h3, 8'h00);
		@(posedge clk) {r2, r1} <= 2'b01;
		repeat (4) @(posedge clk);
		rreg(4'h3, 8'h03);
		chk({6'h00, f2, f1}, 8'h03);
		wreg(4'h3, 8'h01);
		rreg(4'h3, 8'h02);
		wreg(4'h3, 8'h02);
		@(posedge clk) {r2, r1} <= 2'b10;
		repeat (4) @(posedge clk);
		rreg(4'h3, 8'h00);
		chk({6'h00, f2, f1}, 8'h00);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		rreg(4'h0, 8'h00);
		conclude();
	end
endmodule : test_cmpsel_top
`default_nettype wire
